//--- core/fhc_top.sv
// Overview of operation
// (R1) Chip erase is opcode 60 or C7 alone
// (R2) Write enable precedes every chip erase
// (R3) Chip select rises only after whole byte
// (R4) Flash shows busy during erase, then clears latch
// (R5) Flash erases chip only when unprotected
// (R6) Page write: 02, three address bytes, data
// (R7) Write enable precedes every page write
// (R8) Flash wraps address within 256-byte page
// (R9) Flash keeps only last 256 bytes sent
// (R10) Short page write leaves other bytes alone
// (R11) Select held low, raised after whole byte
// (R12) Flash shows busy during program, clears latch
// (R13) Flash skips write to protected page
// (R14) Dual page write A2, data on two lines
// (R15) Write enable precedes dual page write
// (R16) Quad write 32 needs latch and quad enable
// (R17) Three separate 512-byte security registers exist
// (R18) Security erase 44 with 24-bit address
// (R19) Security address: 00, index, zeros, ignored
// (R20) Flash shows busy during security erase
// (R21) Locked security registers ignore erase forever
// (R22) Upper lines unused in single-line commands
// (R23) Shift most significant bit first
// (R24) Refused commands change nothing in the flash
`timescale 1ns/1ns
module fhc_top
  import fhc_pkg::*;
#(
  parameter int SCLK_HALF_CYC = 4
) (
  // Clock and reset
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  RST_IN,
  // AXI4-Lite register slave
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                  S_AXI_AWVALID_IN,
  output logic                       S_AXI_AWREADY_OUT,
  input  wire logic [31:0]           S_AXI_WDATA_IN,
  input  wire logic [3:0]            S_AXI_WSTRB_IN,
  input  wire logic                  S_AXI_WVALID_IN,
  output logic                       S_AXI_WREADY_OUT,
  output logic [1:0]                 S_AXI_BRESP_OUT,
  output logic                       S_AXI_BVALID_OUT,
  input  wire logic                  S_AXI_BREADY_IN,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                  S_AXI_ARVALID_IN,
  output logic                       S_AXI_ARREADY_OUT,
  output logic [31:0]                S_AXI_RDATA_OUT,
  output logic [1:0]                 S_AXI_RRESP_OUT,
  output logic                       S_AXI_RVALID_OUT,
  input  wire logic                  S_AXI_RREADY_IN,
  // Flash pins
  output logic                       FLASH_CS_N_OUT,
  output logic                       FLASH_SCLK_OUT,
  output logic [3:0]                 FLASH_IO_OUT,
  output logic [3:0]                 FLASH_IO_OE_N_OUT,
  input  wire logic [3:0]            FLASH_IO_IN
);

  localparam int GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  if (GAP_CYC < 1 || GAP_CYC > 15) begin : g_chk
    $error("Chip select gap must fit a four-bit counter");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WEN,
    ST_GAP,
    ST_OP,
    ST_ADDR,
    ST_DATA,
    ST_POLL_OP,
    ST_POLL_RD
  } fhc_state_e;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_LEN) ||
             (a == REG_DATA) || (a == REG_STATUS);
  endfunction

  function automatic logic is_page(input logic [2:0] op);
    is_page = (op == OP_PAGE1) || (op == OP_PAGE2) || (op == OP_PAGE4);
  endfunction

  // Register bus side
  logic                  wr_en;
  fhc_wr_s               wr;
  logic                  wr_err;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_err;

  // Software registers
  logic [2:0]  op_q;
  logic        qe_q;
  logic        poll_q;
  logic        go_q;
  logic [23:0] addr_q;
  logic [8:0]  len_q;
  logic [8:0]  wptr_q;
  logic [7:0]  buf_q [PAGE_BYTES];
  logic [31:0] addr_m;
  logic [31:0] len_m;
  logic        wr_ok;

  // Sequencer
  fhc_state_e  st_q;
  fhc_state_e  ret_q;
  logic        cs_n_q;
  logic        pend_q;
  logic        busy_q;
  logic        err_q;
  logic        done_q;
  logic [1:0]  idx_q;
  logic [8:0]  cnt_q;
  logic [3:0]  gap_q;
  logic [7:0]  fstat_q;
  logic        bad;
  logic        fin_now;
  logic        send;
  logic        start;
  fhc_spi_req_s req;
  logic [23:0] fl_addr;
  logic        eng_done;
  logic [7:0]  eng_rx;

  fhc_axil_slave u_bus (
    .clk_in      (CORE_CLK_IN),
    .rst_in      (RST_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .araddr_in   (S_AXI_ARADDR_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .wr_en_out   (wr_en),
    .wr_out      (wr),
    .wr_err_in   (wr_err),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data),
    .rd_err_in   (rd_err)
  );

  fhc_spi_engine #(
    .HALF_CYC (SCLK_HALF_CYC)
  ) u_eng (
    .clk_in      (CORE_CLK_IN),
    .rst_in      (RST_IN),
    .start_in    (start),
    .req_in      (req),
    .done_out    (eng_done),
    .rx_out      (eng_rx),
    .sclk_out    (FLASH_SCLK_OUT),
    .io_out      (FLASH_IO_OUT),
    .io_oe_n_out (FLASH_IO_OE_N_OUT),
    .io_in       (FLASH_IO_IN)
  );

  // Address decode and read mux
  always_comb begin
    wr_err  = !mapped(wr.addr);
    rd_err  = !mapped(rd_addr);
    addr_m  = merge({8'h00, addr_q}, wr.data, wr.strb);
    len_m   = merge({23'h00_0000, len_q}, wr.data, wr.strb);
    wr_ok   = wr_en && !busy_q;
    rd_data = 32'h0000_0000;
    if (rd_addr == REG_CTRL) begin
      rd_data[CTRL_OP_LSB +: 3] = op_q;
      rd_data[CTRL_QE_BIT]      = qe_q;
      rd_data[CTRL_POLL_BIT]    = poll_q;
    end else if (rd_addr == REG_ADDR) begin
      rd_data[23:0] = addr_q;
    end else if (rd_addr == REG_LEN) begin
      rd_data[8:0] = len_q;
    end else if (rd_addr == REG_DATA) begin
      rd_data[8:0] = wptr_q;
    end else if (rd_addr == REG_STATUS) begin
      rd_data[STAT_BUSY_BIT]    = busy_q;
      rd_data[STAT_ERR_BIT]     = err_q;
      rd_data[STAT_DONE_BIT]    = done_q;
      rd_data[STAT_FL_LSB +: 8] = fstat_q;
    end
  end

  // Control registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      op_q   <= CTRL_OP_RST;
      qe_q   <= 1'b0;
      poll_q <= CTRL_POLL_RST;
      go_q   <= 1'b0;
      addr_q <= 24'h00_0000;
      len_q  <= 9'h000;
    end else begin
      go_q <= 1'b0;
      if (wr_ok && wr.addr == REG_CTRL && wr.strb[0]) begin
        go_q   <= wr.data[CTRL_GO_BIT];
        op_q   <= wr.data[CTRL_OP_LSB +: 3];
        qe_q   <= wr.data[CTRL_QE_BIT];
        poll_q <= wr.data[CTRL_POLL_BIT];
      end
      if (wr_ok && wr.addr == REG_ADDR) begin
        addr_q <= addr_m[23:0];
      end
      if (wr_ok && wr.addr == REG_LEN) begin
        len_q <= len_m[8:0];
      end
    end
  end

  // Buffer fill; rewinds at command end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      wptr_q <= 9'h000;
    end else if (st_q == ST_GAP && ret_q == ST_IDLE && gap_q == 4'(GAP_CYC - 1)) begin
      wptr_q <= 9'h000;
    end else if (wr_ok && wr.addr == REG_DATA && wr.strb[0] && wptr_q < 9'(PAGE_BYTES)) begin
      wptr_q <= wptr_q + 9'h001;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (wr_ok && wr.addr == REG_DATA && wr.strb[0] && wptr_q < 9'(PAGE_BYTES)) begin
      buf_q[wptr_q[7:0]] <= wr.data[7:0];
    end
  end

  // Refusal checks
  always_comb begin
    bad = (op_q > OP_SECREG) ||
          (is_page(op_q) && (len_q == 9'h000 || len_q > 9'(PAGE_BYTES))) || // R9
          (op_q == OP_PAGE4 && !qe_q) || // R16
          (op_q == OP_SECREG && addr_q[1:0] == 2'b00); // R17
    fl_addr = addr_q;
    if (op_q == OP_SECREG) begin
      fl_addr = {8'h00, 2'b00, addr_q[1:0], 3'b000, 9'h000}; // R19
    end
    fin_now = eng_done &&
              ((st_q == ST_OP && (op_q == OP_CHIP_C7 || op_q == OP_CHIP_60)) ||
               (st_q == ST_ADDR && idx_q == 2'(ADDR_BYTES - 1) && op_q == OP_SECREG) ||
               (st_q == ST_DATA && cnt_q == len_q - 9'h001)); // R3 R11
  end

  // Byte to send in each state but idle and gap
  always_comb begin
    req.data  = 8'h00;
    req.lanes = LANES_1; // R22
    send      = 1'b1;
    unique case (st_q)
      ST_IDLE, ST_GAP: send = 1'b0;
      ST_WEN: req.data = OPC_WRITE_ENABLE_CMD; // R2 R7 R15 R16 R18
      ST_OP: begin
        unique case (op_q)
          OP_CHIP_C7: req.data = OPC_CHIP_B; // R1
          OP_CHIP_60: req.data = OPC_CHIP_A; // R1
          OP_PAGE1:   req.data = OPC_PAGE1; // R6
          OP_PAGE2:   req.data = OPC_PAGE2; // R14
          OP_PAGE4:   req.data = OPC_PAGE4; // R16
          default:    req.data = OPC_SECERASE; // R18
        endcase
      end
      ST_ADDR: begin
        unique case (idx_q)
          2'h0:    req.data = fl_addr[23:16]; // R23
          2'h1:    req.data = fl_addr[15:8];
          default: req.data = fl_addr[7:0];
        endcase
      end
      ST_DATA: begin
        req.data  = buf_q[cnt_q[7:0]];
        req.lanes = (op_q == OP_PAGE2) ? LANES_2 :
                    (op_q == OP_PAGE4) ? LANES_4 : LANES_1; // R14 R16
      end
      ST_POLL_OP: req.data = OPC_RDSR;
      ST_POLL_RD: req.data = 8'h00;
    endcase
    start = send && !pend_q;
  end

  // Command sequencer
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_q    <= ST_IDLE;
      ret_q   <= ST_IDLE;
      cs_n_q  <= 1'b1;
      pend_q  <= 1'b0;
      busy_q  <= 1'b0;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
      idx_q   <= 2'h0;
      cnt_q   <= 9'h000;
      gap_q   <= 4'h0;
      fstat_q <= 8'h00;
    end else begin
      if (start) begin
        pend_q <= 1'b1;
      end else if (eng_done) begin
        pend_q <= 1'b0;
      end
      if (fin_now) begin
        cs_n_q <= 1'b1; // R3 R11
        gap_q  <= 4'h0;
        ret_q  <= poll_q ? ST_POLL_OP : ST_IDLE;
        st_q   <= ST_GAP;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            if (go_q) begin
              done_q <= 1'b0;
              err_q  <= bad;
              if (!bad) begin
                busy_q <= 1'b1;
                cs_n_q <= 1'b0;
                st_q   <= ST_WEN;
              end
            end
          end
          ST_WEN: begin
            if (eng_done) begin
              cs_n_q <= 1'b1; // R2 R7
              gap_q  <= 4'h0;
              ret_q  <= ST_OP;
              st_q   <= ST_GAP;
            end
          end
          ST_GAP: begin
            if (gap_q == 4'(GAP_CYC - 1)) begin
              if (ret_q == ST_IDLE) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                st_q   <= ST_IDLE;
              end else begin
                cs_n_q <= 1'b0;
                st_q   <= ret_q;
              end
            end else begin
              gap_q <= gap_q + 4'h1;
            end
          end
          ST_OP: begin
            if (eng_done) begin
              idx_q <= 2'h0;
              cnt_q <= 9'h000;
              st_q  <= ST_ADDR; // R6 R18
            end
          end
          ST_ADDR: begin
            if (eng_done) begin
              idx_q <= idx_q + 2'h1;
              if (idx_q == 2'(ADDR_BYTES - 1)) begin
                st_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (eng_done) begin
              cnt_q <= cnt_q + 9'h001; // R10
            end
          end
          ST_POLL_OP: begin
            if (eng_done) begin
              st_q <= ST_POLL_RD;
            end
          end
          ST_POLL_RD: begin
            if (eng_done) begin
              fstat_q <= eng_rx;
              cs_n_q  <= 1'b1;
              gap_q   <= 4'h0;
              ret_q   <= eng_rx[FL_WIP_BIT] ? ST_POLL_OP : ST_IDLE; // R4 R12 R20
              st_q    <= ST_GAP;
            end
          end
        endcase
      end
    end
  end

  assign FLASH_CS_N_OUT = cs_n_q;

endmodule

//--- core/fhc_pkg.sv
package fhc_pkg;

  // Flash opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD     = 8'h06;
  localparam logic [7:0] OPC_RDSR     = 8'h05;
  localparam logic [7:0] OPC_CHIP_A   = 8'h60;
  localparam logic [7:0] OPC_CHIP_B   = 8'hC7;
  localparam logic [7:0] OPC_PAGE1    = 8'h02;
  localparam logic [7:0] OPC_PAGE2    = 8'hA2;
  localparam logic [7:0] OPC_PAGE4    = 8'h32;
  localparam logic [7:0] OPC_SECERASE = 8'h44;

  // Register address width and offsets
  localparam int         AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_LEN    = 8'h08;
  localparam logic [7:0] REG_DATA   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Control op codes
  localparam logic [2:0] OP_CHIP_C7 = 3'h0;
  localparam logic [2:0] OP_CHIP_60 = 3'h1;
  localparam logic [2:0] OP_PAGE1   = 3'h2;
  localparam logic [2:0] OP_PAGE2   = 3'h3;
  localparam logic [2:0] OP_PAGE4   = 3'h4;
  localparam logic [2:0] OP_SECREG  = 3'h5;

  // Field positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_QE_BIT   = 4;
  localparam int CTRL_POLL_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_FL_LSB   = 8;
  localparam int FL_WIP_BIT    = 0;

  // Reset values
  localparam logic [2:0] CTRL_OP_RST   = OP_CHIP_C7;
  localparam logic       CTRL_POLL_RST = 1'b1;

  // Sizes and timing
  localparam int PAGE_BYTES    = 256;
  localparam int ADDR_BYTES    = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CS_GAP_NS     = 50;

  typedef enum logic [1:0] {
    LANES_1,
    LANES_2,
    LANES_4
  } fhc_lanes_e;

  typedef struct packed {
    logic [7:0] data;
    fhc_lanes_e lanes;
  } fhc_spi_req_s;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] addr;
    logic [31:0]           data;
    logic [3:0]            strb;
  } fhc_wr_s;

endpackage

//--- core/fhc_axil_slave.sv
`timescale 1ns/1ns
module fhc_axil_slave
  import fhc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] awaddr_in,
  input  wire logic                  awvalid_in,
  output logic                       awready_out,
  input  wire logic [31:0]           wdata_in,
  input  wire logic [3:0]            wstrb_in,
  input  wire logic                  wvalid_in,
  output logic                       wready_out,
  output logic [1:0]                 bresp_out,
  output logic                       bvalid_out,
  input  wire logic                  bready_in,
  input  wire logic [AXI_ADDR_W-1:0] araddr_in,
  input  wire logic                  arvalid_in,
  output logic                       arready_out,
  output logic [31:0]                rdata_out,
  output logic [1:0]                 rresp_out,
  output logic                       rvalid_out,
  input  wire logic                  rready_in,
  // Register side
  output logic                       wr_en_out,
  output fhc_wr_s                    wr_out,
  input  wire logic                  wr_err_in,
  output logic [AXI_ADDR_W-1:0]      rd_addr_out,
  input  wire logic [31:0]           rd_data_in,
  input  wire logic                  rd_err_in
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic    aw_rdy_q;
  logic    w_rdy_q;
  logic    ar_rdy_q;
  logic    bvalid_q;
  logic    rvalid_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  fhc_wr_s wr_q;
  logic    wr_fire;

  // Both halves held
  assign wr_fire = !aw_rdy_q && !w_rdy_q && !bvalid_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      wr_q     <= '0;
    end else begin
      if (aw_rdy_q && awvalid_in) begin
        aw_rdy_q  <= 1'b0;
        wr_q.addr <= awaddr_in;
      end
      if (w_rdy_q && wvalid_in) begin
        w_rdy_q   <= 1'b0;
        wr_q.data <= wdata_in;
        wr_q.strb <= wstrb_in;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_err_in ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && bready_in) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_rdy_q && arvalid_in) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data_in;
      rresp_q  <= rd_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready_in) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end

  assign awready_out = aw_rdy_q;
  assign wready_out  = w_rdy_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;
  assign arready_out = ar_rdy_q;
  assign rvalid_out  = rvalid_q;
  assign rresp_out   = rresp_q;
  assign rdata_out   = rdata_q;
  assign wr_en_out   = wr_fire;
  assign wr_out      = wr_q;
  assign rd_addr_out = araddr_in;

endmodule

//--- core/fhc_spi_engine.sv
`timescale 1ns/1ns
module fhc_spi_engine
  import fhc_pkg::*;
#(
  parameter int HALF_CYC = 4
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Byte request
  input  wire logic         start_in,
  input  wire fhc_spi_req_s req_in,
  output logic              done_out,
  output logic [7:0]        rx_out,
  // Flash pins
  output logic              sclk_out,
  output logic [3:0]        io_out,
  output logic [3:0]        io_oe_n_out,
  input  wire logic [3:0]   io_in
);

  if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_chk
    $error("HALF_CYC must lie between 4 and 255");
  end

  function automatic logic [3:0] lane_bits(input logic [7:0] b, input fhc_lanes_e l);
    unique case (l)
      LANES_1: lane_bits = {3'b000, b[7]};
      LANES_2: lane_bits = {2'b00, b[7:6]};
      default: lane_bits = b[7:4];
    endcase
  endfunction

  function automatic logic [7:0] lane_shift(input logic [7:0] b, input fhc_lanes_e l);
    unique case (l)
      LANES_1: lane_shift = {b[6:0], 1'b0};
      LANES_2: lane_shift = {b[5:0], 2'b00};
      default: lane_shift = {b[3:0], 4'h0};
    endcase
  endfunction

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] io_st_q;
  logic       busy_q;
  logic       done_q;
  logic       sclk_q;
  logic [7:0] div_q;
  logic [3:0] grp_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [3:0] io_q;
  logic [3:0] oe_n_q;
  fhc_lanes_e lanes_q;
  logic [7:0] sh_next;

  // Pin synchroniser
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q    <= 4'h0;
      s2_q    <= 4'h0;
      s3_q    <= 4'h0;
      io_st_q <= 4'h0;
    end else begin
      s1_q <= io_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        io_st_q <= s3_q;
      end
    end
  end

  assign sh_next = lane_shift(sh_q, lanes_q);

  // Mode 0 shifter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      sclk_q  <= 1'b0;
      div_q   <= 8'h00;
      grp_q   <= 4'h0;
      sh_q    <= 8'h00;
      rx_q    <= 8'h00;
      io_q    <= 4'h0;
      oe_n_q  <= 4'hF;
      lanes_q <= LANES_1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (start_in) begin
          busy_q  <= 1'b1;
          sh_q    <= req_in.data;
          lanes_q <= req_in.lanes;
          div_q   <= 8'h00;
          io_q    <= lane_bits(req_in.data, req_in.lanes); // R23
          oe_n_q  <= (req_in.lanes == LANES_1) ? 4'hE :
                     (req_in.lanes == LANES_2) ? 4'hC : 4'h0; // R22
          grp_q   <= (req_in.lanes == LANES_1) ? 4'h8 :
                     (req_in.lanes == LANES_2) ? 4'h4 : 4'h2;
        end
      end else if (div_q == 8'(HALF_CYC - 1)) begin
        div_q <= 8'h00;
        if (!sclk_q) begin
          sclk_q <= 1'b1;
        end else begin
          sclk_q <= 1'b0;
          rx_q   <= {rx_q[6:0], io_st_q[1]};
          sh_q   <= sh_next;
          io_q   <= lane_bits(sh_next, lanes_q); // R23
          grp_q  <= grp_q - 4'h1;
          if (grp_q == 4'h1) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign done_out    = done_q;
  assign rx_out      = rx_q;
  assign sclk_out    = sclk_q;
  assign io_out      = io_q;
  assign io_oe_n_out = oe_n_q;

endmodule

//--- tb/fhc_assertions.sv
`timescale 1ns/1ns
module fhc_assertions (
  // Clock, reset and flash pins
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_IN,
  input wire logic       FLASH_CS_N_OUT,
  input wire logic       FLASH_SCLK_OUT,
  input wire logic [3:0] FLASH_IO_OUT,
  input wire logic [3:0] FLASH_IO_OE_N_OUT
);
  logic [15:0] n_q;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || FLASH_CS_N_OUT) n_q <= 16'h0000;
    else if ($rose(FLASH_SCLK_OUT)) n_q <= n_q + 16'h0001;
  end
  sclk_idle_a: assert property (FLASH_CS_N_OUT |-> !FLASH_SCLK_OUT)
    else $error("idle clk");
  byte_edge_a: assert property ($rose(FLASH_CS_N_OUT) |-> !n_q[0])
    else $error("cs mid byte");
  sclk_high_a: assert property ($rose(FLASH_SCLK_OUT) |=> FLASH_SCLK_OUT[*3])
    else $error("short high");
  sclk_low_a: assert property ($fell(FLASH_SCLK_OUT) |=> !FLASH_SCLK_OUT[*3])
    else $error("short low");
  io_stable_a: assert property (FLASH_SCLK_OUT && $past(FLASH_SCLK_OUT) |-> $stable(FLASH_IO_OUT))
    else $error("io moved");
  lane_set_a: assert property (!FLASH_CS_N_OUT |-> FLASH_IO_OE_N_OUT inside {4'hF, 4'hE, 4'hC, 4'h0})
    else $error("lane oe");
  cs_gap_a: assert property ($rose(FLASH_CS_N_OUT) |=> FLASH_CS_N_OUT[*2])
    else $error("short gap");
  cs_low_a: assert property ($fell(FLASH_CS_N_OUT) |=> !FLASH_CS_N_OUT[*8])
    else $error("short cs");
endmodule
bind fhc_top fhc_assertions u_chk (.*);

//--- tb/fhc_flash_model.sv
`timescale 1ns/1ns
module fhc_flash_model (
  // Flash pins
  input  wire logic       cs_n_in,
  input  wire logic       sclk_in,
  input  wire logic [3:0] io_in,
  output logic            so_out,
  // Last command seen other than 06 and 05
  output logic [7:0]      opc_out,
  output logic [23:0]     addr_out,
  output logic [7:0]      byte_out,
  output int              clks_out,
  output int              execs_out,
  output logic            wel_out
);
  logic [31:0] sh;
  logic [23:0] a;
  logic [7:0]  op, st;
  int          n, b, write_in_progress;
  initial {so_out, wel_out, execs_out, write_in_progress, op} = '0;
  always @(negedge cs_n_in) begin
    n = 0;
    b = 0;
    st = {7'h00, write_in_progress != 0};
  end
  always @(posedge sclk_in) if (!cs_n_in) begin
    if (n >= 32 && op == 8'hA2) sh = {sh[29:0], io_in[1:0]};
    else if (n >= 32 && op == 8'h32) sh = {sh[27:0], io_in};
    else sh = {sh[30:0], io_in[0]};
    b += (n < 32) ? 1 : (op == 8'hA2) ? 2 : (op == 8'h32) ? 4 : 1;
    n++;
    if (n == 8) op = sh[7:0];
    if (n == 32) a = sh[23:0];
  end
  // Status byte out
  always @(negedge sclk_in) if (!cs_n_in && op == 8'h05 && n >= 8) begin
    so_out = st[7];
    st = st << 1;
  end
  always @(posedge cs_n_in) begin
    so_out = ~so_out;
    if (op == 8'h06 && b == 8) wel_out = 1'b1;
    else if (op == 8'h05) write_in_progress = (write_in_progress > 0) ? write_in_progress - 1 : 0;
    else begin
      {opc_out, addr_out, byte_out, clks_out} = {op, a, sh[7:0], n};
      if (wel_out && b % 8 == 0) begin
        execs_out++;
        wel_out = 1'b0;
        write_in_progress = 2;
      end
    end
  end
endmodule

//--- tb/fhc_top_tb_top.sv
`timescale 1ns/1ns
module automatic fhc_top_tb_top;
  import fhc_pkg::*;
  logic CORE_CLK_IN, RST_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN, so, write_enable_latch;
  logic S_AXI_ARVALID_IN, S_AXI_RREADY_IN, S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT;
  logic S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, FLASH_CS_N_OUT, FLASH_SCLK_OUT;
  logic [7:0]  S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, opc, db;
  logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, s;
  logic [3:0]  S_AXI_WSTRB_IN, FLASH_IO_OUT, FLASH_IO_OE_N_OUT, FLASH_IO_IN;
  logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, r;
  logic [23:0] ad;
  int          n_fail, checks_done, clks, execs, ex;
  fhc_top uut (.*);
  fhc_flash_model u_flash (.cs_n_in(FLASH_CS_N_OUT), .sclk_in(FLASH_SCLK_OUT), .io_in(FLASH_IO_IN),
    .so_out(so), .opc_out(opc), .addr_out(ad), .byte_out(db), .clks_out(clks), .execs_out(execs),
    .wel_out(write_enable_latch));
  // Pull-ups; io1 from flash
  assign FLASH_IO_IN = (~FLASH_IO_OE_N_OUT & FLASH_IO_OUT) | (FLASH_IO_OE_N_OUT & {2'b11, so, 1'b1});
  initial begin
    CORE_CLK_IN = 1'b0;
    forever #10 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  initial begin
    #1_000_000;
    n_fail++;
    tally_and_finish();
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= d;
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN} <= 2'b11;
    do begin
      @(posedge CORE_CLK_IN);
      if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'b0;
      if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'b0;
    end while (!S_AXI_BVALID_OUT);
    r = S_AXI_BRESP_OUT;
  endtask
  task rd(input logic [7:0] a);
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1'b1;
    do begin
      @(posedge CORE_CLK_IN);
      if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'b0;
    end while (!S_AXI_RVALID_OUT);
    {s, r} = {S_AXI_RDATA_OUT, S_AXI_RRESP_OUT};
  endtask
  task run(input logic [2:0] op, input logic qe, input logic [23:0] a, input logic [8:0] n);
    wr(REG_ADDR, {8'h00, a});
    wr(REG_LEN, {23'h0, n});
    wr(REG_CTRL, {26'h0, 1'b1, qe, op, 1'b1});
    do rd(REG_STATUS); while (s[0]);
  endtask
  task post(input logic [7:0] c, input int k);
    ex++;
    chk("opc", opc, c);
    chk("clks", clks, k);
    chk("exec", execs, ex);
    chk("wel", write_enable_latch, 1'b0);
    chk("stat", s, 32'h0000_0004);
  endtask
  task t_regs();
    rd(REG_CTRL);
    chk("ctrl", s, 32'h0000_0020);
    rd(8'h40);
    chk("rresp", r, 2'h2);
    wr(8'h40, 32'h0000_0000);
    chk("bresp", r, 2'h2);
  endtask
  task t_page();
    logic [7:0] code [3] = '{OPC_PAGE1, OPC_PAGE2, OPC_PAGE4};
    for (int i = 0; i < 3; i++) begin
      wr(REG_DATA, 32'h0000_00A5 + i);
      run(OP_PAGE1 + 3'(i), 1'b1, 24'h12_34FF, 9'h001);
      post(code[i], 32 + (8 >> i));
      chk("addr", ad, 24'h12_34FF);
      chk("data", db, 32'h0000_00A5 + i);
    end
  endtask
  task t_erase();
    for (int i = 0; i < 2; i++) begin
      run(OP_CHIP_C7 + 3'(i), 1'b0, 24'h00_0000, 9'h001);
      post(i ? OPC_CHIP_A : OPC_CHIP_B, 8);
    end
  endtask
  task t_sec();
    for (int i = 1; i < 4; i++) begin
      run(OP_SECREG, 1'b0, 24'(i), 9'h001);
      post(OPC_SECERASE, 32);
      chk("addr", ad, {8'h00, 4'(i), 12'h000});
    end
  endtask
  task t_refuse();
    logic [2:0] op [4] = '{OP_PAGE4, OP_PAGE1, OP_PAGE1, OP_SECREG};
    logic [8:0] ln [4] = '{9'h001, 9'h000, 9'h101, 9'h001};
    for (int i = 0; i < 4; i++) begin
      run(op[i], 1'b0, 24'h00_0100, ln[i]);
      chk("err", s[1], 1'b1);
      chk("exec", execs, ex);
    end
  endtask
  task tally_and_finish();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN, S_AXI_ARVALID_IN, S_AXI_RREADY_IN} = 5'h05;
    {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, S_AXI_WDATA_IN} = '0;
    S_AXI_WSTRB_IN = 4'hF;
    RST_IN = 1'b1;
    {n_fail, checks_done, ex} = '0;
    repeat (6) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    @(posedge CORE_CLK_IN);
    t_regs();
    t_page();
    t_erase();
    t_sec();
    t_refuse();
    tally_and_finish();
  end
endmodule
